// [verilog/lvds_ddr_input_capture.sv]
// DDR input capture of the data lanes and frame marker, with setup registers
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module lvds_ddr_input_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Link pins
   input wire logic [15:0] link_data,
   input wire logic frame_marker,
   input wire logic ddr_capture_clock,
   // Control pins
   input wire logic tx_enable_pin,
   input wire logic chip_clear_n,
   // Reference pin
   input wire logic reference_io_pin_in,
   output logic reference_io_pin_out,
   output logic reference_io_pin_oe_n,
   // Captured stream
   output logic [15:0] word_data,
   output logic word_valid,
   output logic word_is_fall,
   output logic parity_bit,
   output logic frame_start,
   output logic fifo_ptr_reset,
   output logic sync_pulse,
   // Converter control
   output logic [3:0] fullscale_current_code,
   // Alarm and interrupt
   output logic alarm,
   output logic irq
);

   // ==========================================================
   // Input synchronisers
   logic [15:0] data_s;
   logic link_clk_s, frame_s, tx_pin_s, clear_s, ref_in_s, chip_clear_req;

   assign chip_clear_req = ~chip_clear_n;

   sync_two_stage #(.WIDTH(ddr_capture_pkg::LANES)) u_sync_data (
      .clk(clk), .reset_n(reset_n), .async_in(link_data), .sync_out(data_s)
   );
   sync_two_stage #(.WIDTH(1)) u_sync_link_clk (
      .clk(clk), .reset_n(reset_n), .async_in(ddr_capture_clock), .sync_out(link_clk_s)
   );
   sync_two_stage #(.WIDTH(1)) u_sync_frame (
      .clk(clk), .reset_n(reset_n), .async_in(frame_marker), .sync_out(frame_s)
   );
   sync_two_stage #(.WIDTH(1)) u_sync_tx_pin (
      .clk(clk), .reset_n(reset_n), .async_in(tx_enable_pin), .sync_out(tx_pin_s)
   );
   sync_two_stage #(.WIDTH(1)) u_sync_clear (
      .clk(clk), .reset_n(reset_n), .async_in(chip_clear_req), .sync_out(clear_s)
   );
   sync_two_stage #(.WIDTH(1)) u_sync_ref (
      .clk(clk), .reset_n(reset_n), .async_in(reference_io_pin_in), .sync_out(ref_in_s)
   );

   // ==========================================================
   // Programming registers
   logic flip_ff, sync_sel_ff, alarm_pol_ff, tx_soft_ff, ext_ref_ff;
   logic [1:0] mask_ff, evt_en_ff, status_ff;
   logic [3:0] fs_code_ff;

   logic wr_ifc, wr_gen, wr_mask, wr_out, wr_ref, wr_clr, wr_en;

   assign wr_ifc = reg_wr & (reg_addr == ddr_capture_pkg::OFS_INTERFACE_SETUP);
   assign wr_gen = reg_wr & (reg_addr == ddr_capture_pkg::OFS_GENERAL_SETUP);
   assign wr_mask = reg_wr & (reg_addr == ddr_capture_pkg::OFS_ALARM_MASK);
   assign wr_out = reg_wr & (reg_addr == ddr_capture_pkg::OFS_OUTPUT_SETUP);
   assign wr_ref = reg_wr & (reg_addr == ddr_capture_pkg::OFS_REFERENCE_SETUP);
   assign wr_clr = reg_wr & (reg_addr == ddr_capture_pkg::OFS_EVENT_CLEAR);
   assign wr_en = reg_wr & (reg_addr == ddr_capture_pkg::OFS_EVENT_ENABLE);

   // Chip clear outranks any write in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flip_ff <= ddr_capture_pkg::FLIP_RST;
         sync_sel_ff <= ddr_capture_pkg::SYNC_SEL_RST;
         alarm_pol_ff <= ddr_capture_pkg::ALARM_POL_RST;
         mask_ff <= ddr_capture_pkg::ALARM_MASK_RST;
      end else if (clear_s) begin
         flip_ff <= ddr_capture_pkg::FLIP_RST;
         sync_sel_ff <= ddr_capture_pkg::SYNC_SEL_RST;
         alarm_pol_ff <= ddr_capture_pkg::ALARM_POL_RST;
         mask_ff <= ddr_capture_pkg::ALARM_MASK_RST;
      end else begin
         if (wr_ifc) begin
            flip_ff <= reg_wdata[ddr_capture_pkg::IFC_FLIP_BIT];
            sync_sel_ff <= reg_wdata[ddr_capture_pkg::IFC_SYNC_BIT];
         end
         if (wr_gen) begin
            alarm_pol_ff <= reg_wdata[ddr_capture_pkg::GEN_POL_BIT];
         end
         if (wr_mask) begin
            mask_ff <= reg_wdata[ddr_capture_pkg::EVT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fs_code_ff <= ddr_capture_pkg::FS_CODE_RST;
         tx_soft_ff <= ddr_capture_pkg::TX_SOFT_RST;
         ext_ref_ff <= ddr_capture_pkg::EXT_REF_RST;
         evt_en_ff <= ddr_capture_pkg::EVT_EN_RST;
      end else if (clear_s) begin
         fs_code_ff <= ddr_capture_pkg::FS_CODE_RST;
         tx_soft_ff <= ddr_capture_pkg::TX_SOFT_RST;
         ext_ref_ff <= ddr_capture_pkg::EXT_REF_RST;
         evt_en_ff <= ddr_capture_pkg::EVT_EN_RST;
      end else begin
         if (wr_out) begin
            fs_code_ff <= reg_wdata[ddr_capture_pkg::OUT_FS_MSB:ddr_capture_pkg::OUT_FS_LSB];
            tx_soft_ff <= reg_wdata[ddr_capture_pkg::OUT_TXEN_BIT];
         end
         if (wr_ref) begin
            ext_ref_ff <= reg_wdata[ddr_capture_pkg::REF_EXT_BIT];
         end
         if (wr_en) begin
            evt_en_ff <= reg_wdata[ddr_capture_pkg::EVT_W-1:0];
         end
      end
   end

   // ==========================================================
   // Link edge detection and capture
   logic link_clk_prev_ff, rise_det, fall_det, tx_on, take_rise, take_fall;
   logic pair_open_ff, nxt_pair_open, frame_hi_ff;
   logic [15:0] data_rev, data_ord, rise_word_ff;

   // Link clock is oversampled: 200 ns period gives eight system clocks
   assign rise_det = link_clk_s & ~link_clk_prev_ff;
   assign fall_det = ~link_clk_s & link_clk_prev_ff;
   assign tx_on = tx_soft_ff | tx_pin_s;

   for (genvar i = 0; i < ddr_capture_pkg::LANES; i++) begin : g_rev
      assign data_rev[i] = data_s[ddr_capture_pkg::LANES-1-i];
   end

   assign data_ord = flip_ff ? data_rev : data_s;
   assign take_rise = rise_det & tx_on;
   assign take_fall = fall_det & tx_on & pair_open_ff;

   // A falling word without its rising partner is dropped to keep pairs whole
   assign nxt_pair_open = take_rise ? 1'b1 : ((take_fall | ~tx_on) ? 1'b0 : pair_open_ff);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         link_clk_prev_ff <= 1'b0;
         pair_open_ff <= 1'b0;
         rise_word_ff <= 16'h0000;
         frame_hi_ff <= 1'b0;
      end else begin
         link_clk_prev_ff <= link_clk_s;
         pair_open_ff <= nxt_pair_open;
         if (take_rise) begin
            rise_word_ff <= data_ord;
            frame_hi_ff <= frame_s;
         end
      end
   end

   // ==========================================================
   // Frame and parity
   logic new_frame, pair_parity, parity_bad;
   logic [1:0] evt_set;

   assign new_frame = take_rise & frame_s & ~frame_hi_ff;
   assign pair_parity = ^{rise_word_ff, data_ord};
   assign parity_bad = take_fall & (frame_s != pair_parity);
   assign evt_set = {parity_bad, new_frame};

   // ==========================================================
   // Captured stream outputs
   logic [15:0] word_data_ff, nxt_word_data;
   logic word_valid_ff, word_is_fall_ff, nxt_word_is_fall, parity_bit_ff;
   logic frame_start_ff, fifo_ptr_reset_ff, sync_pulse_ff;

   // Disabled datapath is held at zero so stale samples never leak
   assign nxt_word_data = !tx_on ? 16'h0000 :
                          ((take_rise | take_fall) ? data_ord : word_data_ff);
   assign nxt_word_is_fall = take_fall ? 1'b1 : (take_rise ? 1'b0 : word_is_fall_ff);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         word_data_ff <= 16'h0000;
         word_valid_ff <= 1'b0;
         word_is_fall_ff <= 1'b0;
         parity_bit_ff <= 1'b0;
         frame_start_ff <= 1'b0;
         fifo_ptr_reset_ff <= 1'b0;
         sync_pulse_ff <= 1'b0;
      end else begin
         word_data_ff <= nxt_word_data;
         word_valid_ff <= take_rise | take_fall;
         word_is_fall_ff <= nxt_word_is_fall;
         if (take_fall) begin
            parity_bit_ff <= frame_s;
         end
         frame_start_ff <= new_frame;
         fifo_ptr_reset_ff <= new_frame & ~sync_sel_ff;
         sync_pulse_ff <= new_frame & sync_sel_ff;
      end
   end

   // ==========================================================
   // Events, alarm and interrupt
   logic [1:0] clr_bits, nxt_status;
   logic alarm_active, alarm_ff, irq_ff, ref_out_ff, ref_oe_n_ff;

   assign clr_bits = wr_clr ? reg_wdata[ddr_capture_pkg::EVT_W-1:0] : 2'h0;
   // New events win over a clear in the same cycle
   assign nxt_status = (status_ff & ~clr_bits) | evt_set;
   assign alarm_active = |(status_ff & mask_ff);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_ff <= 2'h0;
         alarm_ff <= 1'b1;
         irq_ff <= 1'b0;
         ref_out_ff <= 1'b0;
         ref_oe_n_ff <= 1'b1;
      end else begin
         status_ff <= nxt_status;
         alarm_ff <= alarm_pol_ff ? alarm_active : ~alarm_active;
         irq_ff <= |(status_ff & evt_en_ff);
         ref_out_ff <= ddr_capture_pkg::INTERNAL_REF_LEVEL;
         ref_oe_n_ff <= ext_ref_ff;
      end
   end

   // ==========================================================
   // Read back
   logic [15:0] rd_ifc, rd_gen, rd_mask, rd_out, rd_ref, rd_status, rd_en, rd_link;
   logic [15:0] rd_mux, rdata_ff;

   assign rd_ifc = ({15'h0000, flip_ff} << ddr_capture_pkg::IFC_FLIP_BIT) |
                   ({15'h0000, sync_sel_ff} << ddr_capture_pkg::IFC_SYNC_BIT);
   assign rd_gen = {15'h0000, alarm_pol_ff} << ddr_capture_pkg::GEN_POL_BIT;
   assign rd_mask = {14'h0000, mask_ff};
   assign rd_out = ({12'h000, fs_code_ff} << ddr_capture_pkg::OUT_FS_LSB) |
                   ({15'h0000, tx_soft_ff} << ddr_capture_pkg::OUT_TXEN_BIT);
   assign rd_ref = {15'h0000, ext_ref_ff} << ddr_capture_pkg::REF_EXT_BIT;
   assign rd_status = {14'h0000, status_ff};
   assign rd_en = {14'h0000, evt_en_ff};
   assign rd_link = ({15'h0000, tx_on} << ddr_capture_pkg::LINK_TXON_BIT) |
                    ({15'h0000, ref_in_s} << ddr_capture_pkg::LINK_REFIN_BIT) |
                    ({15'h0000, frame_hi_ff} << ddr_capture_pkg::LINK_FRAME_BIT);

   // Unmapped and write-only offsets read as zero
   assign rd_mux =
      (reg_addr == ddr_capture_pkg::OFS_INTERFACE_SETUP) ? rd_ifc :
      (reg_addr == ddr_capture_pkg::OFS_GENERAL_SETUP) ? rd_gen :
      (reg_addr == ddr_capture_pkg::OFS_ALARM_MASK) ? rd_mask :
      (reg_addr == ddr_capture_pkg::OFS_OUTPUT_SETUP) ? rd_out :
      (reg_addr == ddr_capture_pkg::OFS_REFERENCE_SETUP) ? rd_ref :
      (reg_addr == ddr_capture_pkg::OFS_EVENT_STATUS) ? rd_status :
      (reg_addr == ddr_capture_pkg::OFS_EVENT_ENABLE) ? rd_en :
      (reg_addr == ddr_capture_pkg::OFS_LAST_WORD) ? rise_word_ff :
      (reg_addr == ddr_capture_pkg::OFS_LINK_STATUS) ? rd_link : 16'h0000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ==========================================================
   // Output ports
   assign reg_rdata = rdata_ff;
   assign word_data = word_data_ff;
   assign word_valid = word_valid_ff;
   assign word_is_fall = word_is_fall_ff;
   assign parity_bit = parity_bit_ff;
   assign frame_start = frame_start_ff;
   assign fifo_ptr_reset = fifo_ptr_reset_ff;
   assign sync_pulse = sync_pulse_ff;
   assign fullscale_current_code = fs_code_ff;
   assign alarm = alarm_ff;
   assign irq = irq_ff;
   assign reference_io_pin_out = ref_out_ff;
   assign reference_io_pin_oe_n = ref_oe_n_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence rise_taken_s;
      take_rise;
   endsequence
   sequence fall_taken_s;
      take_fall;
   endsequence
   sequence rise_word_out_s;
      word_valid_ff && !word_is_fall_ff;
   endsequence
   sequence fall_word_out_s;
      word_valid_ff && word_is_fall_ff;
   endsequence

   rise_word_out_a: assert property (rise_taken_s |=> rise_word_out_s)
      else $error("rising edge word not emitted");
   fall_word_out_a: assert property (fall_taken_s |=> fall_word_out_s)
      else $error("falling edge word not emitted");
   fall_after_rise_a: assert property (fall_word_out_s |-> $past(pair_open_ff))
      else $error("falling word without rising partner");
   lane_order_a: assert property (take_rise && !flip_ff |=> word_data_ff == $past(data_s))
      else $error("lane order wrong");
   lane_flip_a: assert property (take_rise && flip_ff |=> word_data_ff == $past(data_rev))
      else $error("flipped lane order wrong");
   frame_ptr_a: assert property (new_frame |=> frame_start_ff
      && (fifo_ptr_reset_ff != sync_pulse_ff) && (sync_pulse_ff == $past(sync_sel_ff)))
      else $error("frame start action wrong");
   parity_flag_a: assert property (parity_bad |=> status_ff[ddr_capture_pkg::EVT_PARITY_BIT]
      ##1 status_ff[ddr_capture_pkg::EVT_PARITY_BIT] || $past(wr_clr))
      else $error("parity error not flagged");
   alarm_level_a: assert property (##1 alarm_ff == ($past(alarm_pol_ff)
      ? $past(alarm_active) : !$past(alarm_active)))
      else $error("alarm polarity wrong");
   alarm_mask_a: assert property ((status_ff & mask_ff) == 2'h0 && !alarm_pol_ff
      |=> alarm_ff)
      else $error("alarm raised for masked source");
   fullscale_a: assert property (wr_out && !clear_s |=> fullscale_current_code
      == $past(reg_wdata[ddr_capture_pkg::OUT_FS_MSB:ddr_capture_pkg::OUT_FS_LSB]))
      else $error("full-scale code not applied");
   ref_dir_a: assert property (wr_ref && !clear_s ##1 1'b1 |=> reference_io_pin_oe_n
      == $past(reg_wdata[ddr_capture_pkg::REF_EXT_BIT], 2))
      else $error("reference pin direction wrong");
   tx_off_a: assert property (!tx_on |=> !word_valid_ff && word_data_ff == 16'h0000)
      else $error("disabled datapath not zero");
   chip_clear_a: assert property (clear_s |=> !flip_ff && mask_ff == 2'h0
      && fs_code_ff == ddr_capture_pkg::FS_CODE_RST && !tx_soft_ff && !ext_ref_ff)
      else $error("chip clear did not restore defaults");
   set_wins_a: assert property (new_frame && wr_clr
      |=> status_ff[ddr_capture_pkg::EVT_FRAME_BIT])
      else $error("event lost against clear");

endmodule : lvds_ddr_input_capture

// [verilog/ddr_capture_pkg.sv]
// Constants shared by the DDR input capture block
package ddr_capture_pkg;

   // ==========================================================
   // Widths
   localparam int LANES = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int EVT_W = 2;
   localparam int FS_W = 4;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_INTERFACE_SETUP = 8'h00;
   localparam logic [7:0] OFS_GENERAL_SETUP = 8'h01;
   localparam logic [7:0] OFS_ALARM_MASK = 8'h02;
   localparam logic [7:0] OFS_OUTPUT_SETUP = 8'h03;
   localparam logic [7:0] OFS_REFERENCE_SETUP = 8'h04;
   localparam logic [7:0] OFS_EVENT_STATUS = 8'h05;
   localparam logic [7:0] OFS_EVENT_CLEAR = 8'h06;
   localparam logic [7:0] OFS_EVENT_ENABLE = 8'h07;
   localparam logic [7:0] OFS_LAST_WORD = 8'h08;
   localparam logic [7:0] OFS_LINK_STATUS = 8'h09;

   // ==========================================================
   // Field positions
   localparam int IFC_FLIP_BIT = 0;
   localparam int IFC_SYNC_BIT = 1;
   localparam int GEN_POL_BIT = 0;
   localparam int OUT_TXEN_BIT = 0;
   localparam int OUT_FS_LSB = 12;
   localparam int OUT_FS_MSB = 15;
   localparam int REF_EXT_BIT = 0;
   localparam int EVT_FRAME_BIT = 0;
   localparam int EVT_PARITY_BIT = 1;
   localparam int LINK_TXON_BIT = 0;
   localparam int LINK_REFIN_BIT = 1;
   localparam int LINK_FRAME_BIT = 2;

   // ==========================================================
   // Reset values
   localparam logic FLIP_RST = 1'b0;
   localparam logic SYNC_SEL_RST = 1'b0;
   localparam logic ALARM_POL_RST = 1'b0;
   localparam logic [1:0] ALARM_MASK_RST = 2'h0;
   localparam logic [3:0] FS_CODE_RST = 4'hF;
   localparam logic TX_SOFT_RST = 1'b0;
   localparam logic EXT_REF_RST = 1'b0;
   localparam logic [1:0] EVT_EN_RST = 2'h0;
   localparam logic INTERNAL_REF_LEVEL = 1'b1;

endpackage : ddr_capture_pkg

// [verilog/sync_two_stage.sv]
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps

module sync_two_stage #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Signals
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule : sync_two_stage

// [tb/link_source_model.sv]
// Behavioural far-end logic driving DDR words, frame marker and link clock
`timescale 1ns/1ps

module link_source_model (
   // Link pins
   output logic [15:0] link_data,
   output logic frame_marker,
   output logic ddr_capture_clock
);
   initial begin
      link_data = 16'h0000;
      frame_marker = 1'b0;
      ddr_capture_clock = 1'b0;
   end

   // ==========================================================
   // One rising/falling pair, 200 ns link period
   // Clock stands still between pairs; released lines flip so stale values never pass
   task automatic send_pair(input logic [15:0] rw, input logic [15:0] fw, input logic fr,
                            input logic bad);
      logic par;
      par = ^{rw, fw} ^ bad;
      link_data = rw;
      frame_marker = fr;
      #50 ddr_capture_clock = 1'b1;
      #50 link_data = fw;
      frame_marker = par;
      #50 ddr_capture_clock = 1'b0;
      #50 link_data = ~fw;
      frame_marker = ~par;
   endtask : send_pair
endmodule : link_source_model

// [tb/lvds_ddr_input_capture_tb_top.sv]
// Self-checking bench for the DDR input capture block
`timescale 1ns/1ps

module lvds_ddr_input_capture_tb_top;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic flip, sync, fr, eptr, esync;
      logic [15:0] rw, fw, er, ef;
   } row_t;
   logic clk, reset_n, reg_wr, reg_rd, tx_enable_pin, chip_clear_n, reference_io_pin_in;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, link_data, word_data, rv;
   logic frame_marker, ddr_capture_clock, reference_io_pin_out, reference_io_pin_oe_n;
   logic word_valid, word_is_fall, parity_bit, frame_start, fifo_ptr_reset, sync_pulse;
   logic alarm, irq;
   logic [3:0] fullscale_current_code;
   int num_errors, total_checks, cycles, n_ptr, n_sync, n_start;
   logic [16:0] q[$];
   row_t rows [0:4];
   logic [7:0] ra [0:8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h20};
   logic [15:0] rx [0:8] = '{16'h0000, 16'h0000, 16'h0000, 16'hF000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000};

   // Open-drain style reference pin: device level when driving, else external low
   assign reference_io_pin_in = reference_io_pin_oe_n ? 1'b0 : reference_io_pin_out;

   lvds_ddr_input_capture lvds_ddr_input_capture_inst (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_data(link_data),
      .frame_marker(frame_marker), .ddr_capture_clock(ddr_capture_clock),
      .tx_enable_pin(tx_enable_pin), .chip_clear_n(chip_clear_n),
      .reference_io_pin_in(reference_io_pin_in), .reference_io_pin_out(reference_io_pin_out),
      .reference_io_pin_oe_n(reference_io_pin_oe_n), .word_data(word_data),
      .word_valid(word_valid), .word_is_fall(word_is_fall), .parity_bit(parity_bit),
      .frame_start(frame_start), .fifo_ptr_reset(fifo_ptr_reset), .sync_pulse(sync_pulse),
      .fullscale_current_code(fullscale_current_code), .alarm(alarm), .irq(irq));

   link_source_model link_source_model_inst (
      .link_data(link_data), .frame_marker(frame_marker),
      .ddr_capture_clock(ddr_capture_clock));

   // ==========================================================
   // Clock, monitor and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (word_valid === 1'b1) q.push_back({word_is_fall, word_data});
      if (fifo_ptr_reset === 1'b1) n_ptr++;
      if (sync_pulse === 1'b1) n_sync++;
      if (frame_start === 1'b1) n_start++;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic clks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : clks

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      clks(2);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic pair(input logic [15:0] rw, input logic [15:0] fw, input logic fr,
                       input logic bad);
      q.delete();
      n_ptr = 0;
      n_sync = 0;
      n_start = 0;
      #7 link_source_model_inst.send_pair(rw, fw, fr, bad);
      clks(8);
   endtask : pair

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      tx_enable_pin = 1'b1;
      chip_clear_n = 1'b1;
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      // Rows: flip sync fr eptr esync, rise, fall, expected rise, expected fall
      rows[0] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h8001, 16'h1234, 16'h8001, 16'h1234};
      rows[1] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};
      rows[2] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0001, 16'h00F0, 16'h8000, 16'h0F00};
      rows[3] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 16'hABCD, 16'h2C48, 16'hB3D5};
      rows[4] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'hA5A5, 16'h5A5A, 16'hA5A5, 16'h5A5A};
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      clks(3);
      chk({15'h0000, alarm}, 16'h0001);
      chk({14'h0000, reference_io_pin_out, reference_io_pin_oe_n}, 16'h0002);
      for (int i = 0; i < 9; i++) begin
         rd(ra[i], rv);
         chk(rv, rx[i]);
      end
      for (int i = 0; i < 5; i++) begin
         wr(ddr_capture_pkg::OFS_INTERFACE_SETUP, {14'h0000, rows[i].sync, rows[i].flip});
         pair(rows[i].rw, rows[i].fw, rows[i].fr, 1'b0);
         chk(16'(q.size()), 16'h0002);
         chk(q[0][15:0], rows[i].er);
         chk(q[1][15:0], rows[i].ef);
         chk({14'h0000, q[0][16], q[1][16]}, 16'h0001);
         chk({15'h0000, parity_bit}, {15'h0000, ^{rows[i].rw, rows[i].fw}});
         chk(16'(n_ptr * 2 + n_sync), {14'h0000, rows[i].eptr, rows[i].esync});
         chk(16'(n_start), {15'h0000, rows[i].eptr | rows[i].esync});
      end
      // Alarm and interrupt: masked, unmasked, both polarities
      wr(ddr_capture_pkg::OFS_EVENT_CLEAR, 16'h0003);
      pair(16'h0001, 16'h0001, 1'b1, 1'b0);
      rd(ddr_capture_pkg::OFS_EVENT_STATUS, rv);
      chk(rv, 16'h0001);
      chk({14'h0000, alarm, irq}, 16'h0002);
      wr(ddr_capture_pkg::OFS_ALARM_MASK, 16'h0001);
      chk({15'h0000, alarm}, 16'h0000);
      wr(ddr_capture_pkg::OFS_GENERAL_SETUP, 16'h0001);
      wr(ddr_capture_pkg::OFS_EVENT_ENABLE, 16'h0001);
      chk({14'h0000, alarm, irq}, 16'h0003);
      wr(ddr_capture_pkg::OFS_EVENT_CLEAR, 16'h0001);
      chk({14'h0000, alarm, irq}, 16'h0000);
      // Corrupted block parity on the falling sample
      pair(16'h1111, 16'h2222, 1'b0, 1'b1);
      chk({15'h0000, parity_bit}, 16'h0001);
      rd(ddr_capture_pkg::OFS_EVENT_STATUS, rv);
      chk(rv, 16'h0002);
      // Full-scale code, then transmit off by both pin and soft bit
      wr(ddr_capture_pkg::OFS_OUTPUT_SETUP, 16'h9000);
      chk({12'h000, fullscale_current_code}, 16'h0009);
      tx_enable_pin <= 1'b0;
      clks(4);
      pair(16'h7777, 16'h3333, 1'b0, 1'b0);
      chk(16'(q.size()), 16'h0000);
      chk(word_data, 16'h0000);
      wr(ddr_capture_pkg::OFS_REFERENCE_SETUP, 16'h0001);
      chk({15'h0000, reference_io_pin_oe_n}, 16'h0001);
      wr(ddr_capture_pkg::OFS_REFERENCE_SETUP, 16'h0000);
      chk({14'h0000, reference_io_pin_out, reference_io_pin_oe_n}, 16'h0002);
      // Chip clear restores programming registers, status survives
      chip_clear_n <= 1'b0;
      clks(5);
      chip_clear_n <= 1'b1;
      clks(4);
      rd(ddr_capture_pkg::OFS_GENERAL_SETUP, rv);
      chk(rv, 16'h0000);
      chk({11'h000, alarm, fullscale_current_code}, 16'h001F);
      rd(ddr_capture_pkg::OFS_EVENT_STATUS, rv);
      chk(rv, 16'h0002);
      // Clear written every cycle while a frame starts: one frame_start and the rising word must still appear
      tx_enable_pin <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ddr_capture_pkg::OFS_EVENT_CLEAR;
      reg_wdata <= 16'h0003;
      pair(16'h0F0F, 16'h00FF, 1'b1, 1'b0);
      @(posedge clk);
      reg_wr <= 1'b0;
      chk(16'(n_start), 16'h0001);
      chk(q[0][15:0], 16'h0F0F);
      tally_and_finish();
   end
endmodule : lvds_ddr_input_capture_tb_top
